//--- rtl/amcg_top.sv
module amcg_top #(
	parameter int CNT_W = amcg_pkg::CNT_W
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// register access from the serial control bus
	input wire amcg_pkg::amcg_reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	// audio
	input wire logic i2s_bclk,
	input wire logic audio_pll_en,
	output logic mclk_out
);

	localparam logic [CNT_W-1:0] LOSS =
		CNT_W'(amcg_pkg::BCLK_LOSS_CYC);

	// ------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------
	function automatic logic [1:0] band_of(input logic [CNT_W-1:0] p);
		logic [1:0] b;
		b = 2'h3;
		if (p > CNT_W'(amcg_pkg::BAND1_CYC))
			b = 2'h0;
		else if (p > CNT_W'(amcg_pkg::BAND2_CYC))
			b = 2'h1;
		else if (p > CNT_W'(amcg_pkg::BAND3_CYC))
			b = 2'h2;
		return b;
	endfunction

	// code names an absolute band; the shift is its distance from the
	// bit clock band, clamped to the x1..x4 range the divider supports
	function automatic logic [1:0] shift_of(input logic [3:0] c,
			input logic [CNT_W-1:0] p);
		logic [3:0] code;
		logic [3:0] band;
		logic [1:0] s;
		code = {1'b0, c[2:0]};
		band = {2'b00, band_of(p)};
		s = amcg_pkg::SHIFT_DEFAULT;
		if (c[3]) begin
			if (code <= band)
				s = 2'h0;
			else if (code - band >= 4'(amcg_pkg::SHIFT_MAX))
				s = amcg_pkg::SHIFT_MAX;
			else
				s = 2'(code - band);
		end
		return s;
	endfunction

	function automatic logic [CNT_W-1:0] half_of(input logic [CNT_W-1:0] p,
			input logic [1:0] s);
		logic [CNT_W-1:0] h;
		h = p >> (s + 2'h1);
		if (h == '0)
			h = CNT_W'(1);
		return h;
	endfunction

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	logic [3:0] ctrl;
	logic [3:0] next_ctrl;
	logic [7:0] next_reg_rdata;
	logic hit;

	assign hit = (reg_req.addr == amcg_pkg::CTRL_ADDR);

	always_comb begin
		next_ctrl = ctrl;
		next_reg_rdata = reg_rdata;
		if (clk_en) begin
			if (reg_req.wr && hit)
				next_ctrl = reg_req.wdata[amcg_pkg::OVR_BIT -: 4];
			if (reg_req.rd)
				next_reg_rdata = hit ? {ctrl, amcg_pkg::CTRL_LOW_READ}
					: amcg_pkg::UNMAPPED_READ;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ctrl <= amcg_pkg::CTRL_RESET;
			reg_rdata <= amcg_pkg::UNMAPPED_READ;
		end else begin
			ctrl <= next_ctrl;
			reg_rdata <= next_reg_rdata;
		end
	end

	// ------------------------------------------------------------
	// bit clock sampling and period measurement
	// ------------------------------------------------------------
	logic bclk_s;
	logic bclk_d;
	logic rise;
	logic lost;

	amcg_sync u_bclk_sync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.async_in(i2s_bclk),
		.sync_out(bclk_s)
	);

	assign rise = bclk_s && !bclk_d;

	// ------------------------------------------------------------
	// mclk generator
	// ------------------------------------------------------------
	amcg_pkg::amcg_state_e state;
	amcg_pkg::amcg_state_e next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] ph;
	logic [CNT_W-1:0] next_ph;
	logic [CNT_W-1:0] half;
	logic [CNT_W-1:0] next_half;
	logic [1:0] cur_sh;
	logic [1:0] next_sh;
	logic [2:0] tog;
	logic [2:0] next_tog;
	logic [2:0] tog_lim;
	logic next_bclk_d;
	logic next_mclk;

	assign lost = (cnt == LOSS);
	// edges in one bit clock period, less the one made at resync
	assign tog_lim = 3'((4'h2 << cur_sh) - 4'h1);

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_ph = ph;
		next_half = half;
		next_sh = cur_sh;
		next_tog = tog;
		next_mclk = mclk_out;
		next_bclk_d = bclk_d;
		if (clk_en) begin
			next_bclk_d = bclk_s;
			if (rise)
				next_cnt = CNT_W'(1);
			else if (!lost)
				next_cnt = cnt + CNT_W'(1);
			case (state)
			amcg_pkg::ST_OFF: begin
				next_mclk = 1'b0;
				if (audio_pll_en && rise)
					next_state = amcg_pkg::ST_MEAS;
			end
			amcg_pkg::ST_MEAS: begin
				next_mclk = 1'b0;
				if (!audio_pll_en || lost) begin
					next_state = amcg_pkg::ST_OFF;
				end else if (rise) begin
					next_state = amcg_pkg::ST_RUN;
					next_sh = shift_of(ctrl, cnt);
					next_half = half_of(cnt, shift_of(ctrl, cnt));
					next_mclk = 1'b1;
					next_ph = CNT_W'(1);
					next_tog = 3'h0;
				end
			end
			amcg_pkg::ST_RUN: begin
				if (!audio_pll_en || lost) begin
					next_state = amcg_pkg::ST_OFF;
					next_mclk = 1'b0;
				end else if (rise) begin
					// rate changes only here and on entry from ST_MEAS, on a rising mclk edge
					next_sh = shift_of(ctrl, cnt);
					next_half = half_of(cnt, shift_of(ctrl, cnt));
					next_mclk = 1'b1;
					next_ph = CNT_W'(1);
					next_tog = 3'h0;
				end else if (ph >= half && tog < tog_lim) begin
					next_mclk = !mclk_out;
					next_ph = CNT_W'(1);
					next_tog = tog + 3'h1;
				end else if (ph != LOSS) begin
					next_ph = ph + CNT_W'(1);
				end
			end
			default: begin
				next_state = amcg_pkg::ST_OFF;
				next_mclk = 1'b0;
			end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state <= amcg_pkg::ST_OFF;
			cnt <= '0;
			ph <= '0;
			half <= CNT_W'(1);
			cur_sh <= amcg_pkg::SHIFT_DEFAULT;
			tog <= 3'h0;
			mclk_out <= 1'b0;
			bclk_d <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			ph <= next_ph;
			half <= next_half;
			cur_sh <= next_sh;
			tog <= next_tog;
			mclk_out <= next_mclk;
			bclk_d <= next_bclk_d;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	property p_pll_off;
		(clk_en && !audio_pll_en) |=> !mclk_out;
	endproperty
	a_pll_off: assert property (p_pll_off)
		else $error("mclk running with pll disabled");

	property p_off_low;
		(state != amcg_pkg::ST_RUN) |-> !mclk_out;
	endproperty
	a_off_low: assert property (p_off_low)
		else $error("mclk high while off");

	property p_resync;
		(clk_en && state == amcg_pkg::ST_RUN && audio_pll_en && rise
			&& !lost) |=> mclk_out;
	endproperty
	a_resync: assert property (p_resync)
		else $error("mclk not aligned to bit clock edge");

	property p_default_x2;
		(clk_en && rise && !lost && audio_pll_en && !ctrl[3]
			&& state != amcg_pkg::ST_OFF) |=> cur_sh == 2'h1;
	endproperty
	a_default_x2: assert property (p_default_x2)
		else $error("default multiple is not x2");

	property p_ctrl_write;
		(clk_en && reg_req.wr && hit) |=> ctrl == $past(reg_req.wdata[7:4]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control field not written");

	property p_ctrl_read;
		(clk_en && reg_req.rd && hit)
			|=> reg_rdata == {$past(ctrl), 4'h0};
	endproperty
	a_ctrl_read: assert property (p_ctrl_read)
		else $error("control readback wrong");

	property p_top_code;
		(clk_en && rise && !lost && audio_pll_en && ctrl == 4'he
			&& band_of(cnt) == 2'h3 && state != amcg_pkg::ST_OFF)
			|=> cur_sh == 2'h2;
	endproperty
	a_top_code: assert property (p_top_code)
		else $error("code 110 not x4 on top band");

	property p_band_shift;
		(clk_en && rise && !lost && audio_pll_en && ctrl == 4'hc
			&& band_of(cnt) == 2'h3 && state != amcg_pkg::ST_OFF)
			|=> cur_sh == 2'h1;
	endproperty
	a_band_shift: assert property (p_band_shift)
		else $error("code 100 not x2 one band above bit clock");

	property p_lost_off;
		(clk_en && lost && state == amcg_pkg::ST_RUN)
			|=> state == amcg_pkg::ST_OFF ##0 !mclk_out;
	endproperty
	a_lost_off: assert property (p_lost_off)
		else $error("mclk kept after bit clock loss");

	property p_freeze;
		!clk_en |=> $stable(mclk_out) && $stable(ctrl) && $stable(state);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved with clock enable low");

	c_run: cover property (state == amcg_pkg::ST_RUN ##1 $fell(mclk_out));
	c_x4: cover property (state == amcg_pkg::ST_RUN && cur_sh == 2'h2);
	c_ovr: cover property (state == amcg_pkg::ST_RUN && ctrl[3]);
	c_stop: cover property (state == amcg_pkg::ST_RUN
		##1 state == amcg_pkg::ST_OFF);

endmodule // amcg_top

//--- rtl/amcg_pkg.sv
package amcg_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_ADDR = 8'h3a;
	localparam int OVR_BIT = 7;
	localparam int CODE_LSB = 4;
	localparam int CODE_W = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [3:0] CTRL_LOW_READ = 4'h0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ------------------------------------------------------------
	// multiplier as a shift: 0 = x1, 1 = x2, 2 = x4
	// ------------------------------------------------------------
	localparam logic [1:0] SHIFT_DEFAULT = 2'h1;
	localparam logic [1:0] SHIFT_MAX = 2'h2;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int REF_CLK_MHZ = 250;
	localparam int CNT_W = 10;
	// bit clock considered lost after this long without a rising edge
	localparam int BCLK_LOSS_NS = 2000;
	localparam int BCLK_LOSS_CYC = BCLK_LOSS_NS * REF_CLK_MHZ / 1000;
	// bit clock band edges, as longest period of the band above
	localparam int BAND1_KHZ = 2000;
	localparam int BAND2_KHZ = 4000;
	localparam int BAND3_KHZ = 8000;
	localparam int BAND1_CYC = REF_CLK_MHZ * 1000 / BAND1_KHZ;
	localparam int BAND2_CYC = REF_CLK_MHZ * 1000 / BAND2_KHZ;
	localparam int BAND3_CYC = REF_CLK_MHZ * 1000 / BAND3_KHZ;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF = 3'b001,
		ST_MEAS = 3'b010,
		ST_RUN = 3'b100
	} amcg_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} amcg_reg_req_s;

endpackage

//--- rtl/amcg_sync.sv
module amcg_sync (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// level in and out
	input wire logic async_in,
	output logic sync_out
);

	logic meta;
	logic next_meta;
	logic next_sync_out;

	always_comb begin
		next_meta = meta;
		next_sync_out = sync_out;
		if (clk_en) begin
			next_meta = async_in;
			next_sync_out = meta;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			meta <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta <= next_meta;
			sync_out <= next_sync_out;
		end
	end

endmodule // amcg_sync

//--- dv/amcg_codec_model.sv
module amcg_codec_model (
	// master clock from the device
	input wire logic mclk,
	// observation
	output logic [15:0] rises
);
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// codec side: counts master clock rising edges
	// ------------------------------------------------------------
	initial begin
		rises = 16'h0000;
	end

	always @(posedge mclk) begin
		rises <= rises + 16'h0001;
	end
endmodule // amcg_codec_model

//--- dv/amcg_top_tb.sv
module amcg_top_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic clk_en = 1'b1;
	logic i2s_bclk = 1'b0;
	logic bclk_run = 1'b0;
	logic audio_pll_en = 1'b0;
	logic mclk_out;
	logic [7:0] reg_rdata;
	logic [7:0] rd_val;
	logic [15:0] rises;
	logic [15:0] r0;
	amcg_pkg::amcg_reg_req_s reg_req = '0;
	int miscompares = 0;
	int n_checks = 0;
	int i;
	logic [7:0] ovr_val[5] = '{8'h80, 8'hb0, 8'hc0, 8'hd0, 8'he0};
	logic [15:0] ovr_exp[5] = '{16'h0010, 16'h0010, 16'h0020, 16'h0040,
		16'h0040};

	// ------------------------------------------------------------
	// clocks: bit clock 32 ns, offset so its edges miss ref_clk edges
	// ------------------------------------------------------------
	always #2 ref_clk = ~ref_clk;

	initial begin
		#1;
		forever #16 i2s_bclk = bclk_run ? ~i2s_bclk : 1'b0;
	end

	amcg_top #(.CNT_W(amcg_pkg::CNT_W)) uut (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.reg_req(reg_req),
		.reg_rdata(reg_rdata),
		.i2s_bclk(i2s_bclk),
		.audio_pll_en(audio_pll_en),
		.mclk_out(mclk_out)
	);

	amcg_codec_model codec (
		.mclk(mclk_out),
		.rises(rises)
	);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(negedge ref_clk);
		reg_req.wr = 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		reg_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(negedge ref_clk);
		reg_req.rd = 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask

	// mclk rises over 16 bit clock periods of 8 ref_clk cycles
	task automatic rate(output logic [15:0] n);
		repeat (64) @(negedge ref_clk);
		r0 = rises;
		repeat (128) @(negedge ref_clk);
		n = rises - r0;
	endtask

	task automatic close_out;
		$display("checks=%0d mismatches=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#200000;
		miscompares++;
		$display("watchdog expired");
		close_out();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(negedge ref_clk);
		resetn = 1'b1;
		reg_rd(amcg_pkg::CTRL_ADDR, rd_val);
		check({8'h00, rd_val}, 16'h0000);
		reg_rd(8'h10, rd_val);
		check({8'h00, rd_val}, 16'h0000);
		$display("test reset done");
		bclk_run = 1'b1;
		rate(r0);
		check(r0, 16'h0000);
		check({15'h0000, mclk_out}, 16'h0000);
		audio_pll_en = 1'b1;
		rate(r0);
		check(r0, 16'h0020);
		$display("test default done");
		for (i = 0; i < 5; i++) begin
			reg_wr(amcg_pkg::CTRL_ADDR, ovr_val[i]);
			reg_rd(amcg_pkg::CTRL_ADDR, rd_val);
			check({8'h00, rd_val}, {8'h00, ovr_val[i]});
			rate(r0);
			check(r0, ovr_exp[i]);
		end
		reg_wr(amcg_pkg::CTRL_ADDR, 8'hdf);
		reg_rd(amcg_pkg::CTRL_ADDR, rd_val);
		check({8'h00, rd_val}, 16'h00d0);
		reg_wr(amcg_pkg::CTRL_ADDR, 8'h50);
		rate(r0);
		check(r0, 16'h0020);
		reg_wr(8'h3b, 8'h80);
		clk_en = 1'b0;
		reg_wr(amcg_pkg::CTRL_ADDR, 8'he0);
		clk_en = 1'b1;
		reg_rd(amcg_pkg::CTRL_ADDR, rd_val);
		check({8'h00, rd_val}, 16'h0050);
		$display("test override done");
		reg_wr(amcg_pkg::CTRL_ADDR, 8'hd0);
		audio_pll_en = 1'b0;
		repeat (2) @(negedge ref_clk);
		check({15'h0000, mclk_out}, 16'h0000);
		rate(r0);
		check(r0, 16'h0000);
		audio_pll_en = 1'b1;
		rate(r0);
		check(r0, 16'h0040);
		bclk_run = 1'b0;
		repeat (600) @(negedge ref_clk);
		rate(r0);
		check(r0, 16'h0000);
		check({15'h0000, mclk_out}, 16'h0000);
		bclk_run = 1'b1;
		rate(r0);
		check(r0, 16'h0040);
		$display("test off and restart done");
		resetn = 1'b0;
		repeat (3) @(negedge ref_clk);
		resetn = 1'b1;
		reg_rd(amcg_pkg::CTRL_ADDR, rd_val);
		check({8'h00, rd_val}, 16'h0000);
		rate(r0);
		check(r0, 16'h0020);
		$display("test second reset done");
		close_out();
	end
endmodule // amcg_top_tb
